// ---- shared/pmbus_agg_regs.vh ----
// constants for the aggregate block read responder
`ifndef PMBUS_AGG_REGS_VH
`define PMBUS_AGG_REGS_VH

// command codes
`define CMD_TELEMETRY_SNAPSHOT 8'hDA
`define CMD_STATUS_SNAPSHOT 8'hDB

// block lengths in bytes
`define LEN_TELEMETRY_SNAPSHOT 8'h0E
`define LEN_STATUS_SNAPSHOT 8'h07

// telemetry block field positions
`define TEL_DUTY_HI 111
`define TEL_DUTY_LO 96
`define TEL_IIN_HI 95
`define TEL_IIN_LO 80
`define TEL_VIN_HI 79
`define TEL_VIN_LO 64
`define TEL_TEMP_HI 63
`define TEL_TEMP_LO 48
`define TEL_IOUT_HI 47
`define TEL_IOUT_LO 32
`define TEL_VOUT_HI 31
`define TEL_VOUT_LO 16
`define TEL_STATUS_HI 15
`define TEL_STATUS_LO 0

// status block byte positions, least significant first
`define STA_VOUT_LO 0
`define STA_IOUT_LO 8
`define STA_INPUT_LO 16
`define STA_TEMP_LO 24
`define STA_CML_LO 32
`define STA_OTHER_LO 40
`define STA_MFR_LO 48

// communication fault bit in the status byte, invalid command bit in the cml status
`define STATUS_BYTE_CML_BIT 1
`define CML_INVALID_CMD_BIT 7

// reset values and fill
`define UNSUPPORTED_FIELD 16'h0000
`define DISABLED_FIELD 16'h0000
`define READ_FILL_BYTE 8'hFF
`define BLOCK_RESET 112'h0

// read answer latency in clock cycles
`define READ_LATENCY_CYCLES 1

`endif

// ---- verilog/sticky_flag.v ----
// sticky event flag where a set in the same cycle as a clear wins
`timescale 1ns/1ps
module sticky_flag (
  input wire clk,
  input wire rst_n,
  input wire setPulse,
  input wire clearPulse,
  output reg flag
);
  always @(posedge clk) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (setPulse) begin
      flag <= 1'b1;
    end else if (clearPulse) begin
      flag <= 1'b0;
    end
  end
endmodule

// ---- verilog/pmbus_aggregate_block_reads.v ----
// responder for the telemetry and status aggregate block read commands
//
// Overview of operation
// - command DAh answers a 14-byte block read of status word and telemetry
// - command DAh accepts no writes; only block read is defined
// - duty cycle bits 111:96 and input current bits 95:80 always read zero
// - layout: vin 79:64, temp 63:48, iout 47:32, vout 31:16, status word 15:0
// - any write to either aggregate command is an invalid command fault
// - fault sets status byte cml bit and cml status bit 7
// - fault notifies host through the alert signal
// - command DBh answers 7 status bytes: vout, iout, input, temp, cml, other, mfr
// - command DBh accepts no writes; only block read is defined
// - a write to the status command clears no asserted status bit
// - both commands are global, not per phase, with no nonvolatile copy
// - disabled telemetry quantity reports zero in its field
`timescale 1ns/1ps
`include "pmbus_agg_regs.vh"
module pmbus_aggregate_block_reads #(
  parameter CODE_W = 8
) (
  input wire clk,
  input wire rst_n,
  // transaction strobes from the pmbus target front end
  input wire cmdValid,
  input wire [CODE_W-1:0] cmdCode,
  input wire wrByteValid,
  input wire [7:0] wrByte,
  input wire rdByteReq,
  input wire txnStop,
  input wire clearFaults,
  // live telemetry and status
  input wire [15:0] statusWordIn,
  input wire [15:0] vinIn,
  input wire [15:0] tempIn,
  input wire [15:0] ioutIn,
  input wire [15:0] voutIn,
  input wire vinDisabled,
  input wire ioutDisabled,
  input wire voutDisabled,
  input wire [7:0] statusVoutIn,
  input wire [7:0] statusIoutIn,
  input wire [7:0] statusInputIn,
  input wire [7:0] statusTempIn,
  input wire [7:0] statusCmlIn,
  input wire [7:0] statusOtherIn,
  input wire [7:0] statusMfrIn,
  // answers
  output reg rdByteValid,
  output reg [7:0] rdByte,
  output reg cmdClaimed,
  output reg invalidCommandFlag,
  output reg statusByteCmlBit,
  output reg alertOut,
  output reg alertOe
);

  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_CMD = 5'b00010;
  localparam [4:0] ST_DATA = 5'b00100;
  localparam [4:0] ST_FAULT = 5'b01000;
  localparam [4:0] ST_DONE = 5'b10000;

  reg [4:0] state_reg;
  reg [4:0] state_next;
  localparam integer SNAP_BYTES = 16;

  reg [7:0] snap_reg [0:SNAP_BYTES-1];
  reg [3:0] index_reg;
  reg [3:0] index_next;
  reg loadSnap;
  integer b;
  reg [7:0] remain_reg;
  reg [7:0] remain_next;
  reg isStatusCmd_reg;
  reg isStatusCmd_next;
  reg [7:0] byteOut_next;
  reg byteValid_next;
  reg faultPulse;

  wire ourCode;
  wire faultFlag;
  wire [111:0] telemetryBlock;
  wire [55:0] statusBlock;
  wire [15:0] statusWordLive;
  wire [7:0] statusCmlLive;
  wire isTelemetryCode;
  wire isStatusCode;
  wire [15:0] vinField;
  wire [15:0] ioutField;
  wire [15:0] voutField;
  wire [127:0] blockSel;

  // both codes are single global registers; no phase select takes part
  assign isTelemetryCode = (cmdCode == `CMD_TELEMETRY_SNAPSHOT);
  assign isStatusCode = (cmdCode == `CMD_STATUS_SNAPSHOT);
  assign ourCode = isTelemetryCode || isStatusCode;

  // our own fault is merged so the host sees it even before the status owner updates
  assign statusWordLive = statusWordIn | ({{15{1'b0}}, faultFlag} << `STATUS_BYTE_CML_BIT);
  assign statusCmlLive = statusCmlIn | ({{7{1'b0}}, faultFlag} << `CML_INVALID_CMD_BIT);

  // unsupported fields are constant zero
  assign telemetryBlock[`TEL_DUTY_HI:`TEL_DUTY_LO] = `UNSUPPORTED_FIELD;
  assign telemetryBlock[`TEL_IIN_HI:`TEL_IIN_LO] = `UNSUPPORTED_FIELD;
  // disabled quantities read zero; temperature cannot be disabled
  assign vinField = vinDisabled ? `DISABLED_FIELD : vinIn;
  assign ioutField = ioutDisabled ? `DISABLED_FIELD : ioutIn;
  assign voutField = voutDisabled ? `DISABLED_FIELD : voutIn;
  assign telemetryBlock[`TEL_VIN_HI:`TEL_VIN_LO] = vinField;
  assign telemetryBlock[`TEL_TEMP_HI:`TEL_TEMP_LO] = tempIn;
  assign telemetryBlock[`TEL_IOUT_HI:`TEL_IOUT_LO] = ioutField;
  assign telemetryBlock[`TEL_VOUT_HI:`TEL_VOUT_LO] = voutField;
  assign telemetryBlock[`TEL_STATUS_HI:`TEL_STATUS_LO] = statusWordLive;

  // padded to whole store entries; the top two entries are never read
  assign blockSel = isStatusCmd_reg ? {{72{1'b0}}, statusBlock} : {{16{1'b0}}, telemetryBlock};

  // status bytes in order from the least significant
  assign statusBlock[`STA_VOUT_LO+7:`STA_VOUT_LO] = statusVoutIn;
  assign statusBlock[`STA_IOUT_LO+7:`STA_IOUT_LO] = statusIoutIn;
  assign statusBlock[`STA_INPUT_LO+7:`STA_INPUT_LO] = statusInputIn;
  assign statusBlock[`STA_TEMP_LO+7:`STA_TEMP_LO] = statusTempIn;
  assign statusBlock[`STA_CML_LO+7:`STA_CML_LO] = statusCmlLive;
  assign statusBlock[`STA_OTHER_LO+7:`STA_OTHER_LO] = statusOtherIn;
  assign statusBlock[`STA_MFR_LO+7:`STA_MFR_LO] = statusMfrIn;

  // invalid command flag; a new fault in the clear cycle is kept
  sticky_flag u_invalid_flag (
    .clk(clk),
    .rst_n(rst_n),
    .setPulse(faultPulse),
    .clearPulse(clearFaults),
    .flag(faultFlag)
  );

  // block frozen at the count byte so a long read never mixes two telemetry updates
  always @(posedge clk) begin
    if (!rst_n) begin
      for (b = 0; b < SNAP_BYTES; b = b + 1) begin
        snap_reg[b] <= 8'h00;
      end
    end else if (loadSnap) begin
      for (b = 0; b < SNAP_BYTES; b = b + 1) begin
        snap_reg[b] <= blockSel[8*b +: 8];
      end
    end
  end

  always @* begin
    state_next = state_reg;
    index_next = index_reg;
    loadSnap = 1'b0;
    remain_next = remain_reg;
    isStatusCmd_next = isStatusCmd_reg;
    byteOut_next = `READ_FILL_BYTE;
    byteValid_next = 1'b0;
    faultPulse = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (cmdValid && ourCode) begin
          isStatusCmd_next = isStatusCode;
          state_next = ST_CMD;
        end
      end
      ST_CMD: begin
        if (txnStop) begin
          state_next = ST_IDLE;
        end else if (wrByteValid) begin
          // no write form exists for either code; data is dropped
          faultPulse = 1'b1;
          state_next = ST_FAULT;
        end else if (rdByteReq) begin
          // one command code then the whole block, count first
          byteValid_next = 1'b1;
          if (isStatusCmd_reg) begin
            byteOut_next = `LEN_STATUS_SNAPSHOT;
            remain_next = `LEN_STATUS_SNAPSHOT;
          end else begin
            byteOut_next = `LEN_TELEMETRY_SNAPSHOT;
            remain_next = `LEN_TELEMETRY_SNAPSHOT;
          end
          // snapshot taken here so the block is coherent across bytes
          loadSnap = 1'b1;
          index_next = 4'h0;
          state_next = ST_DATA;
        end
      end
      ST_DATA: begin
        if (txnStop) begin
          state_next = ST_IDLE;
        end else if (rdByteReq) begin
          // low byte first, stepping toward the most significant
          byteValid_next = 1'b1;
          byteOut_next = snap_reg[index_reg];
          index_next = index_reg + 4'h1;
          remain_next = remain_reg - 8'h01;
          if (remain_reg == 8'h01) begin
            state_next = ST_DONE;
          end
        end else if (wrByteValid) begin
          faultPulse = 1'b1;
          state_next = ST_FAULT;
        end
      end
      ST_FAULT: begin
        // further write bytes are ignored; status is never cleared here
        if (txnStop) begin
          state_next = ST_IDLE;
        end else if (rdByteReq) begin
          byteValid_next = 1'b1;
        end
      end
      ST_DONE: begin
        // reads past the block end return the fill byte
        if (txnStop) begin
          state_next = ST_IDLE;
        end else if (rdByteReq) begin
          byteValid_next = 1'b1;
        end else if (wrByteValid) begin
          // a write after the block is still a write to a read-only command
          faultPulse = 1'b1;
          state_next = ST_FAULT;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      index_reg <= 4'h0;
      remain_reg <= 8'h00;
      isStatusCmd_reg <= 1'b0;
      rdByteValid <= 1'b0;
      rdByte <= 8'h00;
      cmdClaimed <= 1'b0;
    end else begin
      state_reg <= state_next;
      index_reg <= index_next;
      remain_reg <= remain_next;
      isStatusCmd_reg <= isStatusCmd_next;
      rdByteValid <= byteValid_next;
      rdByte <= byteValid_next ? byteOut_next : rdByte;
      cmdClaimed <= (state_next != ST_IDLE);
    end
  end

  // status and alert outputs follow the sticky flag one cycle later
  always @(posedge clk) begin
    if (!rst_n) begin
      invalidCommandFlag <= 1'b0;
      statusByteCmlBit <= 1'b0;
      alertOut <= 1'b0;
      alertOe <= 1'b0;
    end else begin
      invalidCommandFlag <= faultFlag;
      statusByteCmlBit <= faultFlag | statusWordIn[`STATUS_BYTE_CML_BIT];
      // open-drain alert pulled low while the fault stands
      alertOut <= 1'b0;
      alertOe <= faultFlag;
    end
  end

endmodule

// ---- verification/pmbus_agg_checker.sv ----
// port checker for the aggregate block read responder
`timescale 1ns/1ps
`include "pmbus_agg_regs.vh"
module pmbus_agg_checker #(parameter CODE_W = 8) (
  input logic clk,
  input logic rst_n,
  input logic cmdValid,
  input logic [CODE_W-1:0] cmdCode,
  input logic wrByteValid,
  input logic rdByteReq,
  input logic txnStop,
  input logic clearFaults,
  input logic [15:0] statusWordIn,
  input logic rdByteValid,
  input logic cmdClaimed,
  input logic invalidCommandFlag,
  input logic statusByteCmlBit,
  input logic alertOut,
  input logic alertOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire aggCode = cmdCode == `CMD_TELEMETRY_SNAPSHOT || cmdCode == `CMD_STATUS_SNAPSHOT;
  claim_cmd_a: assert property (cmdValid && !cmdClaimed |=> cmdClaimed == $past(aggCode)) else $error("claim");
  read_answer_a: assert property (rdByteReq && cmdClaimed && !txnStop |=> rdByteValid) else $error("rd");
  answer_cause_a: assert property (rdByteValid |-> $past(rdByteReq && cmdClaimed)) else $error("cause");
  write_fault_a: assert property (cmdClaimed && wrByteValid && !txnStop |-> ##2 invalidCommandFlag) else $error("wr");
  fault_cause_a: assert property ($rose(invalidCommandFlag) |-> $past(wrByteValid, 2)) else $error("set");
  flag_hold_a: assert property ($fell(invalidCommandFlag) |-> $past(clearFaults, 2)) else $error("clr");
  alert_flag_a: assert property (alertOe == invalidCommandFlag && !alertOut) else $error("alert");
  // guarded one cycle past reset, since the status input is live during reset
  cml_bit_a: assert property ($past(rst_n) |-> statusByteCmlBit == ($past(statusWordIn[1]) || invalidCommandFlag))
    else $error("cml");
  cover property (cmdValid && aggCode && cmdCode[0]);
  cover property (cmdValid && aggCode && !cmdCode[0]);
  cover property ($fell(invalidCommandFlag));
endmodule

// ---- verification/pmbus_host_model.sv ----
// host controller model issuing byte level transaction strobes
`timescale 1ns/1ps
module pmbus_host_model (
  input logic clk,
  output logic cmdValid = 1'b0,
  output logic [7:0] cmdCode = 8'h00,
  output logic wrByteValid = 1'b0,
  output logic rdByteReq = 1'b0,
  output logic txnStop = 1'b0
);
  task cmd(input [7:0] c, input bit w);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdCode <= c;
    @(posedge clk);
    cmdValid <= 1'b0;
    wrByteValid <= w;
    @(posedge clk);
    wrByteValid <= 1'b0;
  endtask
  // whole block in one run of reads, no second address or command byte
  task rd(input int n);
    rdByteReq <= 1'b1;
    repeat (n) @(posedge clk);
    rdByteReq <= 1'b0;
    repeat (3) @(posedge clk);
    txnStop <= 1'b1;
    @(posedge clk);
    txnStop <= 1'b0;
  endtask
endmodule

// ---- verification/pmbus_aggregate_block_reads_bench.sv ----
// self-checking bench for the aggregate block read responder
`timescale 1ns/1ps
`include "pmbus_agg_regs.vh"
module pmbus_aggregate_block_reads_bench;
  logic clk = 1'b0, rst_n = 1'b0, clearFaults = 1'b0, ef = 1'b0, vinDisabled, ioutDisabled, voutDisabled;
  logic [15:0] statusWordIn, vinIn, tempIn, ioutIn, voutIn;
  logic [7:0] wrByte, statusVoutIn, statusIoutIn, statusInputIn, statusTempIn, statusCmlIn, statusOtherIn, statusMfrIn;
  logic [31:0] s = 32'd77079;
  logic [111:0] blk;
  logic [7:0] got[$], want[$];
  int num_errors = 0, n_checks = 0;
  wire cmdValid, rdByteReq, txnStop, wrByteValid, rdByteValid, cmdClaimed, invalidCommandFlag, statusByteCmlBit;
  wire alertOut, alertOe;
  wire [7:0] cmdCode, rdByte;
  pmbus_host_model host (.clk, .cmdValid, .cmdCode, .wrByteValid, .rdByteReq, .txnStop);
  pmbus_aggregate_block_reads #(.CODE_W(8)) DUT (.clk, .rst_n, .cmdValid, .cmdCode, .wrByteValid, .wrByte,
    .rdByteReq, .txnStop, .clearFaults, .statusWordIn, .vinIn, .tempIn, .ioutIn, .voutIn, .vinDisabled, .ioutDisabled,
    .voutDisabled, .statusVoutIn, .statusIoutIn, .statusInputIn, .statusTempIn, .statusCmlIn, .statusOtherIn,
    .statusMfrIn, .rdByteValid, .rdByte, .cmdClaimed, .invalidCommandFlag, .statusByteCmlBit, .alertOut, .alertOe);
  always #20 clk = ~clk;
  always @(posedge clk) if (rdByteValid === 1'b1) got.push_back(rdByte);
  function logic [31:0] lfsr();
    for (int k = 0; k < 32; k++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction
  task ck(input [7:0] g, input [7:0] e);
    n_checks++;
    if (g !== e) $display("unexpected at %0t got %h want %h", $time, g, e);
    num_errors += (g !== e);
  endtask
  task rnd;
    {vinIn, tempIn, ioutIn, voutIn} <= {lfsr(), lfsr()};
    {statusWordIn, statusVoutIn, statusIoutIn, statusInputIn, statusTempIn, statusCmlIn, statusOtherIn} <= {lfsr(), lfsr()};
    {statusMfrIn, wrByte, vinDisabled, ioutDisabled, voutDisabled} <= 19'(lfsr());
    @(negedge clk);
  endtask
  task xfer(input [7:0] c, input bit w);
    int n;
    n = c == `CMD_STATUS_SNAPSHOT ? 7 : 14;
    blk = n == 14 ? {32'h0, vinDisabled ? 16'h0 : vinIn, tempIn, ioutDisabled ? 16'h0 : ioutIn,
      voutDisabled ? 16'h0 : voutIn, statusWordIn | {ef, 1'b0}} : {statusMfrIn, statusOtherIn,
      statusCmlIn | {ef, 7'h0}, statusTempIn, statusInputIn, statusIoutIn, statusVoutIn};
    want = {n[7:0]};
    for (int i = 0; i < n; i++) want.push_back(blk[8*i +: 8]);
    want.push_back(8'hFF);
    if (w) want = {8'hFF, 8'hFF};
    got = {};
    host.cmd(c, w);
    host.rd(w ? 2 : n + 2);
    ck(8'(got.size()), 8'(want.size()));
    foreach (want[j]) ck(got[j], want[j]);
  endtask
  initial begin
    rnd;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int t = 0; t < 6; t++) begin
      rnd;
      xfer(t[0] ? `CMD_STATUS_SNAPSHOT : `CMD_TELEMETRY_SNAPSHOT, 1'b0);
    end
    xfer(`CMD_TELEMETRY_SNAPSHOT, 1'b1);
    ef = 1'b1;
    ck({4'h0, invalidCommandFlag, statusByteCmlBit, alertOe, alertOut}, 8'h0E);
    xfer(`CMD_STATUS_SNAPSHOT, 1'b1);
    xfer(`CMD_STATUS_SNAPSHOT, 1'b0);
    @(posedge clk) clearFaults <= 1'b1;
    @(posedge clk) clearFaults <= 1'b0;
    repeat (3) @(posedge clk);
    ck({6'h0, invalidCommandFlag, alertOe}, 8'h00);
    end_sim;
  end
  initial begin
    #400000 num_errors++;
    end_sim;
  end
  task end_sim;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
endmodule
bind pmbus_aggregate_block_reads pmbus_agg_checker #(.CODE_W(CODE_W)) chk (.clk, .rst_n, .cmdValid, .cmdCode,
  .wrByteValid, .rdByteReq, .txnStop, .clearFaults, .statusWordIn, .rdByteValid, .cmdClaimed, .invalidCommandFlag,
  .statusByteCmlBit, .alertOut, .alertOe);
